// ---- common/host_port_pkg.sv ----
// constants, register map and types for the host port shutdown block
// Overview of operation
// RL1: shutdown floats all always-covered host pins
// RL2: optional pins float only when function selected
// RL3: smi pin floats only if enabled
// RL4: power event pin floats only if enabled
// RL5: fast gate a20 pin floats only if enabled
// RL6: shutdown request input stays live in shutdown
// RL7: uncovered pins, lpc reset, keep working
// RL8: shutdown initialises state machine and bits
// RL9: priority: sys, lpc hw, soft, hw sd, sw sd
// RL10: system reset initialises every bit, channel enables
// RL11: lpc reset clears soft reset, both shutdown bits
// RL12: soft reset clears both shutdown bits
// RL13: hardware shutdown clears software shutdown bit
// RL14: interrupt requests sent on serial irq line
// RL15: count lclk from every start frame
// RL16: drive request only in its own slot
// RL17: frame ends recovery high, then turnaround released
// RL18: recovery driven by previous state's driver
package host_port_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_EVENT = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0c;
	localparam logic [7:0] ADDR_SERIRQ = 8'h10;

	// control register fields
	localparam int CTRL_W = 9;
	localparam int CTRL_SOFT_RESET = 0;
	localparam int CTRL_HW_SD_EN = 1;
	localparam int CTRL_SW_SD = 2;
	localparam int CTRL_SMI_EN = 3;
	localparam int CTRL_PME_EN = 4;
	localparam int CTRL_GA20_EN = 5;
	localparam int CTRL_CH1_EN = 6;
	localparam int CTRL_CH2_EN = 7;
	localparam int CTRL_CH3_EN = 8;
	localparam logic [8:0] CTRL_RESET = 9'h000;

	// status register fields
	localparam int STAT_SHUTDOWN = 0;
	localparam int STAT_HW_SD = 1;
	localparam int STAT_LRESET = 2;
	localparam int STAT_SOFT_RST = 3;
	localparam int STAT_BUSY = 4;

	// event bits, same layout in mask register
	localparam int EVENT_W = 4;
	localparam int EV_SHUTDOWN = 0;
	localparam int EV_LRESET = 1;
	localparam int EV_SENT = 2;
	localparam int EV_START = 3;
	localparam logic [3:0] EVENT_RESET = 4'h0;

	// synchronised pin vector positions
	localparam int SYNC_W = 12;
	localparam int S_LAD = 0;
	localparam int S_LFRAME = 4;
	localparam int S_LRESET = 5;
	localparam int S_LCLK = 6;
	localparam int S_SERIRQ = 7;
	localparam int S_CLKRUN = 8;
	localparam int S_LPCPD = 9;
	localparam int S_STANDBY_PIN = 10;
	localparam int S_RES = 11;
	localparam logic [11:0] SYNC_IDLE = 12'hfff;

	// serial irq framing
	localparam int SLOTS = 16;
	localparam logic [4:0] LAST_FRAME = 5'h10;
	localparam logic [3:0] START_MIN_CLKS = 4'h4;
	localparam logic [15:0] PEND_RESET = 16'h0000;

	typedef enum logic [2:0] {
		SQ_IDLE = 3'b000,
		SQ_START = 3'b001,
		SQ_START_TAR = 3'b010,
		SQ_SAMPLE = 3'b011,
		SQ_RECOVER = 3'b100,
		SQ_TAR = 3'b101,
		SQ_STOP = 3'b110,
		SQ_STOP_END = 3'b111
	} serirq_state_t;

endpackage

// ---- logic/serirq_engine.sv ----
// serialized interrupt frame tracker and slot driver
`timescale 1ns/1ns
`default_nettype none
module serirq_engine (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic init,
	input wire logic lclk_rise,
	input wire logic line_i,
	input wire logic [15:0] pending,
	output logic line_o,
	output logic line_oe,
	output logic [15:0] sent,
	output logic start_seen,
	output logic busy
);
	import host_port_pkg::*;

	// whole engine state
	typedef struct packed {
		serirq_state_t st;
		logic [3:0] cnt; // start frame low clocks
		logic [4:0] slot; // current data frame
		logic drove; // we drove the sample phase
		logic o;
		logic oe;
		logic [15:0] sent;
		logic start;
	} eng_t;

	eng_t q, d;

	// frame walk, advanced on each lclk rising edge
	always_comb begin
		d = q;
		d.sent = '0;
		d.start = 1'b0;
		if (init) begin
			d = '0; // RL8
		end else if (lclk_rise) begin
			case (q.st)
				SQ_IDLE: begin
					if (!line_i) begin // RL15
						d.st = SQ_START;
						d.cnt = 4'h1;
					end
				end
				SQ_START: begin
					if (!line_i) begin
						if (q.cnt != 4'hf)
							d.cnt = q.cnt + 4'h1;
					end else if (q.cnt >= START_MIN_CLKS) begin
						// this high clock is the host's recovery
						d.st = SQ_START_TAR;
						d.cnt = 4'h0; // reused to pass the turnaround
						d.start = 1'b1;
					end else begin
						d.st = SQ_IDLE; // too short, a glitch
					end
				end
				SQ_START_TAR: begin
					// first rise opens the turnaround, nobody drives
					if (q.cnt == 4'h0) begin // RL17
						d.cnt = 4'h1;
					end else begin
						d.st = SQ_SAMPLE;
						d.slot = 5'h00;
						if (pending[0]) begin // RL16
							d.o = 1'b0;
							d.oe = 1'b1;
							d.drove = 1'b1;
							d.sent[0] = 1'b1;
						end
					end
				end
				SQ_SAMPLE: begin
					d.st = SQ_RECOVER;
					if (q.drove) begin
						d.o = 1'b1; // RL17
						d.oe = 1'b1; // RL18
					end
				end
				SQ_RECOVER: begin
					d.st = SQ_TAR;
					d.oe = 1'b0; // RL17
					d.drove = 1'b0;
				end
				SQ_TAR: begin
					if (q.slot == LAST_FRAME) begin
						d.st = SQ_STOP;
					end else begin
						d.st = SQ_SAMPLE;
						d.slot = q.slot + 5'h01;
						// slot 16 is never ours
						if (q.slot[3:0] != 4'hf &&
								pending[q.slot[3:0] + 4'h1]) begin // RL16
							d.o = 1'b0;
							d.oe = 1'b1;
							d.drove = 1'b1;
							d.sent[q.slot[3:0] + 4'h1] = 1'b1; // RL14
						end
					end
				end
				SQ_STOP: begin
					if (!line_i)
						d.st = SQ_STOP_END;
				end
				SQ_STOP_END: begin
					if (line_i)
						d.st = SQ_IDLE;
				end
				default: begin
					d = '0;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			q <= '0;
		else
			q <= d;
	end

	assign line_o = q.o;
	assign line_oe = q.oe;
	assign sent = q.sent;
	assign start_seen = q.start;
	assign busy = (q.st != SQ_IDLE);
endmodule
`default_nettype wire

// ---- logic/host_port_shutdown.sv ----
// host port shutdown, reset priority and register slave
`timescale 1ns/1ns
`default_nettype none
module host_port_shutdown (
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	// system reset sources
	input wire logic standby_pin_n,
	input wire logic system_reset_pin_n,
	input wire logic watchdog_channel_zero,
	// host pins
	input wire logic [3:0] lad_i,
	output logic [3:0] lad_o,
	output logic lad_oe,
	input wire logic lframe_n_i,
	input wire logic lreset_n_i,
	input wire logic lclk_i,
	input wire logic serirq_i,
	output logic serirq_o,
	output logic serirq_oe,
	input wire logic clkrun_n_i,
	input wire logic lpcpd_n_i,
	output logic smi_o,
	output logic smi_oe,
	output logic pme_o,
	output logic pme_oe,
	output logic ga20_o,
	output logic ga20_oe,
	// internal interface core side
	input wire logic [3:0] core_lad_o,
	input wire logic core_lad_oe,
	output logic [3:0] core_lad_i,
	output logic core_lframe_n,
	output logic core_clkrun_n,
	input wire logic core_smi_n,
	input wire logic core_pme_n,
	input wire logic core_ga20,
	output logic core_init,
	output logic shutdown,
	output logic [2:0] channel_enable
);
	import host_port_pkg::*;

	// register offset decode, shared by read and write paths
	function automatic logic [2:0] reg_index(input logic [7:0] a);
		case (a)
			ADDR_CTRL: reg_index = 3'h1;
			ADDR_STATUS: reg_index = 3'h2;
			ADDR_EVENT: reg_index = 3'h3;
			ADDR_MASK: reg_index = 3'h4;
			ADDR_SERIRQ: reg_index = 3'h5;
			default: reg_index = 3'h0;
		endcase
	endfunction

	// all block state in one place
	typedef struct packed {
		logic [11:0] sync_m; // first stage, read only by sync_s
		logic [11:0] sync_s; // second stage, used by logic
		logic lclk_prev; // for edge finding
		logic lreset_prev;
		logic sd_prev;
		logic [8:0] ctrl;
		logic [3:0] event_st;
		logic [3:0] mask;
		logic [15:0] pend;
		logic wr_pend; // data phase of a write
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic [3:0] lad_o;
		logic lad_oe;
		logic smi_o;
		logic smi_oe;
		logic pme_o;
		logic pme_oe;
		logic ga20_o;
		logic ga20_oe;
		logic [3:0] lad_in;
		logic lframe_in;
		logic clkrun_in;
		logic init;
		logic sd;
		logic irq;
	} blk_t;

	localparam blk_t BLK_RESET = '{
		sync_m: SYNC_IDLE,
		sync_s: SYNC_IDLE,
		lclk_prev: 1'b1,
		lreset_prev: 1'b1,
		sd_prev: 1'b0,
		ctrl: CTRL_RESET,
		event_st: EVENT_RESET,
		mask: EVENT_RESET,
		pend: PEND_RESET,
		wr_pend: 1'b0,
		wr_addr: 8'h00,
		rdata: 32'h0000_0000,
		lad_o: 4'hf,
		lad_oe: 1'b0,
		smi_o: 1'b1,
		smi_oe: 1'b0,
		pme_o: 1'b1,
		pme_oe: 1'b0,
		ga20_o: 1'b1,
		ga20_oe: 1'b0,
		lad_in: 4'hf,
		lframe_in: 1'b1,
		clkrun_in: 1'b1,
		init: 1'b1,
		sd: 1'b0,
		irq: 1'b0
	};

	blk_t q, d;

	// serial irq engine hookup
	logic eng_o;
	logic eng_oe;
	logic [15:0] eng_sent;
	logic eng_start;
	logic eng_busy;
	logic lclk_rise;

	// engine sees lclk only outside shutdown, inputs float there
	assign lclk_rise = q.sync_s[S_LCLK] & ~q.lclk_prev & ~q.sd;

	serirq_engine u_serirq (
		.hclk(hclk),
		.hresetn(hresetn),
		.init(q.init),
		.lclk_rise(lclk_rise),
		.line_i(q.sync_s[S_SERIRQ] | q.sd),
		.pending(q.pend),
		.line_o(eng_o),
		.line_oe(eng_oe),
		.sent(eng_sent),
		.start_seen(eng_start),
		.busy(eng_busy)
	);

	// next-state logic for the whole block
	always_comb begin
		logic sys_rst;
		logic lrst;
		logic soft_rst;
		logic hw_sd;
		logic sw_sd;
		logic sd_now;
		logic [3:0] ev_set;
		logic [2:0] ridx;
		logic [31:0] rd;
		sys_rst = 1'b0;
		lrst = 1'b0;
		soft_rst = 1'b0;
		hw_sd = 1'b0;
		sw_sd = 1'b0;
		sd_now = 1'b0;
		ev_set = 4'h0;
		ridx = 3'h0;
		rd = 32'h0000_0000;
		d = q;

		// pin synchronisers, two flops before any use
		d.sync_m = {system_reset_pin_n, standby_pin_n, lpcpd_n_i,
			clkrun_n_i, serirq_i, lclk_i, lreset_n_i, lframe_n_i, lad_i};
		d.sync_s = q.sync_m;
		d.lclk_prev = q.sync_s[S_LCLK];

		// reset and shutdown sources
		sys_rst = ~q.sync_s[S_STANDBY_PIN] | ~q.sync_s[S_RES] |
			watchdog_channel_zero;
		lrst = ~q.sync_s[S_LRESET]; // RL7
		soft_rst = q.ctrl[CTRL_SOFT_RESET];
		// request input stays live so shutdown can be left
		hw_sd = q.ctrl[CTRL_HW_SD_EN] & ~q.sync_s[S_LPCPD]; // RL6
		sw_sd = q.ctrl[CTRL_SW_SD];

		// software write in the data phase
		if (q.wr_pend) begin
			case (reg_index(q.wr_addr))
				3'h1: d.ctrl = hwdata[CTRL_W-1:0];
				3'h3: d.event_st = q.event_st & ~hwdata[EVENT_W-1:0];
				3'h4: d.mask = hwdata[EVENT_W-1:0];
				3'h5: d.pend = q.pend | hwdata[SLOTS-1:0];
				default: begin
				end
			endcase
		end

		// sent slots leave pending, a new write in the same cycle wins
		if (q.wr_pend && reg_index(q.wr_addr) == 3'h5)
			d.pend = (q.pend & ~eng_sent) | hwdata[SLOTS-1:0];
		else
			d.pend = d.pend & ~eng_sent;

		// priority chain, highest source applied first
		if (sys_rst) begin // RL9
			d.ctrl = CTRL_RESET; // RL10
			d.mask = EVENT_RESET; // RL10
			d.event_st = EVENT_RESET; // RL10
			d.pend = PEND_RESET; // RL10
		end else if (lrst) begin // RL9
			d.ctrl[CTRL_SOFT_RESET] = 1'b0; // RL11
			d.ctrl[CTRL_HW_SD_EN] = 1'b0; // RL11
			d.ctrl[CTRL_SW_SD] = 1'b0; // RL11
			d.pend = PEND_RESET;
		end else if (soft_rst) begin // RL9
			// soft reset holds until a software write, lpc or system reset clears it
			d.ctrl[CTRL_HW_SD_EN] = 1'b0; // RL12
			d.ctrl[CTRL_SW_SD] = 1'b0; // RL12
			d.pend = PEND_RESET;
		end else if (hw_sd) begin // RL9
			d.ctrl[CTRL_SW_SD] = 1'b0; // RL13
			d.pend = PEND_RESET; // RL8
			sd_now = 1'b1;
		end else if (sw_sd) begin // RL9
			d.pend = PEND_RESET; // RL8
			sd_now = 1'b1;
		end

		d.sd = sd_now;
		d.sd_prev = q.sd;
		// engine and core restart under any reset or shutdown
		d.init = sys_rst | lrst | soft_rst | sd_now; // RL8
		d.lreset_prev = q.sync_s[S_LRESET];

		// events, a set in the clearing cycle wins
		ev_set[EV_SHUTDOWN] = q.sd & ~q.sd_prev;
		ev_set[EV_LRESET] = q.lreset_prev & ~q.sync_s[S_LRESET];
		ev_set[EV_SENT] = |eng_sent;
		ev_set[EV_START] = eng_start;
		if (!sys_rst)
			d.event_st = d.event_st | ev_set;
		d.irq = |(q.event_st & q.mask);

		// pin inputs to the core, lad included, read as idle while shut down
		d.lad_in = q.sd ? 4'hf : q.sync_s[S_LAD+3:S_LAD]; // RL1
		d.lframe_in = q.sd | q.sync_s[S_LFRAME]; // RL1
		d.clkrun_in = q.sd | q.sync_s[S_CLKRUN]; // RL1

		// bidirectional lad floats in shutdown
		d.lad_o = core_lad_o;
		d.lad_oe = core_lad_oe & ~q.sd & ~q.init; // RL1

		// optional pins only owned when their function is selected
		d.smi_o = core_smi_n;
		d.smi_oe = q.ctrl[CTRL_SMI_EN] & ~q.sd; // RL2 RL3
		d.pme_o = core_pme_n;
		d.pme_oe = q.ctrl[CTRL_PME_EN] & ~q.sd; // RL2 RL4
		d.ga20_o = core_ga20;
		d.ga20_oe = q.ctrl[CTRL_GA20_EN] & ~q.sd; // RL2 RL5

		// address phase capture, zero wait states
		d.wr_pend = 1'b0;
		if (hsel && hready && htrans[1]) begin
			d.wr_pend = hwrite;
			d.wr_addr = haddr[7:0];
			if (!hwrite) begin
				ridx = reg_index(haddr[7:0]);
				case (ridx)
					3'h1: rd[CTRL_W-1:0] = q.ctrl;
					3'h2: begin
						rd[STAT_SHUTDOWN] = q.sd;
						rd[STAT_HW_SD] = hw_sd;
						rd[STAT_LRESET] = lrst;
						rd[STAT_SOFT_RST] = soft_rst;
						rd[STAT_BUSY] = eng_busy;
					end
					3'h3: rd[EVENT_W-1:0] = q.event_st;
					3'h4: rd[EVENT_W-1:0] = q.mask;
					3'h5: rd[SLOTS-1:0] = q.pend;
					default: rd = 32'h0000_0000; // unmapped reads zero
				endcase
				d.rdata = rd;
			end
		end
	end

	// single state register for the block
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			q <= BLK_RESET;
		else
			q <= d;
	end

	// bus answers: never stalls, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign irq = q.irq;

	// pin and core side outputs, all from flops
	assign lad_o = q.lad_o;
	assign lad_oe = q.lad_oe;
	assign smi_o = q.smi_o;
	assign smi_oe = q.smi_oe;
	assign pme_o = q.pme_o;
	assign pme_oe = q.pme_oe;
	assign ga20_o = q.ga20_o;
	assign ga20_oe = q.ga20_oe;
	// engine is held in init during shutdown, so it floats too
	assign serirq_o = eng_o; // RL14
	assign serirq_oe = eng_oe; // RL1
	assign core_lad_i = q.lad_in;
	assign core_lframe_n = q.lframe_in;
	assign core_clkrun_n = q.clkrun_in;
	assign core_init = q.init;
	assign shutdown = q.sd;
	assign channel_enable = q.ctrl[CTRL_CH3_EN:CTRL_CH1_EN];
endmodule
`default_nettype wire

// ---- sim/host_port_shutdown_chk.sv ----
// assertions on the host port shutdown block ports
`timescale 1ns/1ns
`default_nettype none
module host_port_shutdown_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic shutdown,
	input wire logic core_init,
	input wire logic lad_oe,
	input wire logic smi_oe,
	input wire logic pme_oe,
	input wire logic ga20_oe,
	input wire logic serirq_o,
	input wire logic serirq_oe,
	input wire logic [3:0] core_lad_i,
	input wire logic core_lframe_n,
	input wire logic core_clkrun_n,
	input wire logic lreset_n_i,
	input wire logic system_reset_pin_n,
	input wire logic watchdog_channel_zero,
	input wire logic [2:0] channel_enable
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// shutdown settled long enough for the registered pin stage
	sequence sd_held;
		shutdown [*4];
	endsequence
	// device slot phases: request low, then recovery high
	sequence slot_low;
		serirq_oe && !serirq_o;
	endsequence
	sequence slot_high;
		serirq_oe && serirq_o;
	endsequence
	a_sd_lad_float: assert property (sd_held |-> !lad_oe && !serirq_oe)
		else $error("host drivers active in shutdown");
	a_sd_inputs_idle: assert property (sd_held |-> core_lframe_n &&
		core_clkrun_n && core_lad_i == 4'hf)
		else $error("host inputs reach core in shutdown");
	a_sd_smi_float: assert property (sd_held |-> !smi_oe)
		else $error("smi pin driven in shutdown");
	a_sd_pme_float: assert property (sd_held |-> !pme_oe)
		else $error("power event pin driven in shutdown");
	a_sd_ga20_float: assert property (sd_held |-> !ga20_oe)
		else $error("gate a20 pin driven in shutdown");
	a_sd_core_init: assert property (sd_held |-> core_init)
		else $error("core not held in init during shutdown");
	a_lreset_init: assert property (!lreset_n_i [*5] |-> core_init)
		else $error("link reset ignored");
	a_sysreset_clear: assert property (!system_reset_pin_n [*5] |->
		core_init && !shutdown && channel_enable == 3'h0)
		else $error("system reset left state behind");
	a_wdog_clear: assert property (watchdog_channel_zero |->
		##[1:2] channel_enable == 3'h0)
		else $error("watchdog reset left channels on");
	a_slot_recover: assert property ($rose(serirq_oe) |->
		slot_low ##[4:12] slot_high)
		else $error("slot not driven low then recovered");
	a_recover_release: assert property (slot_high |-> ##[1:12] !serirq_oe)
		else $error("recovery not followed by turnaround");
	a_release_high: assert property ($fell(serirq_oe) |-> $past(serirq_o))
		else $error("line released without recovery");
endmodule
`default_nettype wire

// ---- sim/serirq_host_model.sv ----
// host side of the serial irq line: link clock, start and stop frames
`timescale 1ns/1ns
`default_nettype none
module serirq_host_model (
	input wire logic go,
	input wire logic dev_o,
	input wire logic dev_oe,
	output logic lclk,
	output logic line,
	output logic [15:0] slots,
	output logic done
);
	logic host_oe; // host drives the line
	logic host_o;
	// pull-up holds the line high when nobody drives
	assign line = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);
	// one link period; line changes 100 ns before the rise, sampled late
	task automatic tick(output logic s);
		#100 lclk = 1'b1;
		#400 lclk = 1'b0;
		#300 s = line;
	endtask
	// clock stands still outside frames
	initial begin
		logic s;
		lclk = 1'b0;
		host_oe = 1'b0;
		host_o = 1'b1;
		slots = 16'h0;
		done = 1'b0;
		forever begin
			@(posedge go);
			// step off the hclk edge so pins never race the sampler
			#20;
			host_oe = 1'b1;
			host_o = 1'b0;
			repeat (4) tick(s);
			host_o = 1'b1;
			tick(s);
			host_oe = 1'b0;
			tick(s);
			for (int k = 0; k < 17; k++) begin
				tick(s);
				if (k < 16) slots[k] = !s;
				tick(s);
				tick(s);
			end
			// stop frame, recovered by the host that drove it
			host_oe = 1'b1;
			host_o = 1'b0;
			repeat (2) tick(s);
			host_o = 1'b1;
			tick(s);
			host_oe = 1'b0;
			tick(s);
			done = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- sim/host_port_shutdown_tb.sv ----
// testbench for the host port shutdown block
`timescale 1ns/1ns
`default_nettype none
module host_port_shutdown_tb;
	import host_port_pkg::*;
	localparam logic [31:0] EN = 32'h1f8; // smi, pme, a20, channels 1..3
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, go, done;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, channel_enable;
	logic standby_pin_n, system_reset_pin_n, watchdog_channel_zero;
	logic [3:0] lad_i, lad_o, core_lad_o, core_lad_i;
	logic lad_oe, lframe_n_i, lreset_n_i, lclk, line, serirq_o, serirq_oe;
	logic clkrun_n_i, lpcpd_n_i, smi_o, smi_oe, pme_o, pme_oe, ga20_o;
	logic ga20_oe, core_lad_oe, core_lframe_n, core_clkrun_n, core_smi_n;
	logic core_pme_n, core_ga20, core_init, shutdown;
	logic [15:0] slots;
	int n_errors = 0;
	int compares = 0;
	host_port_shutdown dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .irq, .standby_pin_n, .system_reset_pin_n,
		.watchdog_channel_zero, .lad_i, .lad_o, .lad_oe, .lframe_n_i,
		.lreset_n_i, .lclk_i(lclk), .serirq_i(line), .serirq_o, .serirq_oe,
		.clkrun_n_i, .lpcpd_n_i, .smi_o, .smi_oe, .pme_o, .pme_oe, .ga20_o,
		.ga20_oe, .core_lad_o, .core_lad_oe, .core_lad_i, .core_lframe_n,
		.core_clkrun_n, .core_smi_n, .core_pme_n, .core_ga20, .core_init,
		.shutdown, .channel_enable);
	serirq_host_model host (.go, .dev_o(serirq_o), .dev_oe(serirq_oe),
		.lclk, .line, .slots, .done);
	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// one single ahb-lite transfer, waits on hready in both phases
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(n, r, e);
	endtask
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// hang guard, run needs about a thirtieth of this
	initial begin
		#2_000_000;
		n_errors++;
		stop_test();
	end
	initial begin
		{hresetn, hsel, hwrite, watchdog_channel_zero, go, htrans} = '0;
		{haddr, hwdata} = '0;
		{lframe_n_i, lreset_n_i, lpcpd_n_i, clkrun_n_i, core_lad_oe} = '1;
		{standby_pin_n, system_reset_pin_n} = '1;
		{core_smi_n, core_pme_n, core_ga20} = '1;
		hsize = 3'b010;
		lad_i = 4'h5;
		core_lad_o = 4'ha;
		cyc(3);
		hresetn <= 1'b1;
		cyc(6);
		rd("ctrl", ADDR_CTRL, 32'h0);
		rd("unmapped", 8'h14, 32'h0);
		chk("smi oe", 32'(smi_oe), 32'h0);
		wr(ADDR_CTRL, EN);
		{core_smi_n, core_pme_n, core_ga20} <= 3'b010;
		cyc(3);
		chk("drive", 32'({lad_oe, smi_oe, pme_oe, ga20_oe}), 32'hf);
		chk("levels", 32'({core_lad_i, lad_o, smi_o, pme_o, ga20_o}), 32'h2d2);
		chk("hresp", 32'(hresp), 32'h0);
		chk("channels", 32'(channel_enable), 32'h7);
		// software shutdown with the frame pin active
		wr(ADDR_MASK, 32'h1);
		{lframe_n_i, clkrun_n_i} <= 2'b00;
		wr(ADDR_CTRL, EN | 32'h4);
		cyc(8);
		chk("sd", 32'({shutdown, core_init, irq}), 32'h7);
		chk("sd pins", 32'({lad_oe, smi_oe, pme_oe, ga20_oe}),
			32'h0);
		chk("sd in", 32'({core_lframe_n, core_clkrun_n, core_lad_i}),
			32'h3f);
		rd("status", ADDR_STATUS, 32'h1);
		rd("event", ADDR_EVENT, 32'h1);
		wr(ADDR_EVENT, 32'h1);
		cyc(2);
		chk("irq clear", 32'(irq), 32'h0);
		{lframe_n_i, clkrun_n_i} <= 2'b11;
		// hardware shutdown wins over the software bit
		lpcpd_n_i <= 1'b0;
		wr(ADDR_CTRL, EN | 32'h6);
		cyc(4);
		rd("hw sd", ADDR_CTRL, EN | 32'h2);
		lpcpd_n_i <= 1'b1;
		cyc(8);
		chk("sd exit", 32'(shutdown), 32'h0);
		wr(ADDR_CTRL, EN | 32'h7);
		cyc(4);
		rd("soft rst", ADDR_CTRL, EN | 32'h1);
		chk("soft init", 32'(core_init), 32'h1);
		lreset_n_i <= 1'b0;
		cyc(6);
		wr(ADDR_CTRL, EN | 32'h7);
		rd("lreset", ADDR_CTRL, EN);
		lreset_n_i <= 1'b1;
		// link reset still acts while shut down
		wr(ADDR_CTRL, EN | 32'h4);
		cyc(8);
		lreset_n_i <= 1'b0;
		cyc(6);
		rd("sd lreset", ADDR_CTRL, EN);
		lreset_n_i <= 1'b1;
		cyc(8);
		chk("init off", 32'({core_init, shutdown}), 32'h0);
		// slots 0, 2 and 15 pending across one frame cycle
		wr(ADDR_SERIRQ, 32'h8005);
		go <= 1'b1;
		cyc(2);
		go <= 1'b0;
		wait (done === 1'b1);
		chk("slots", 32'(slots), 32'h8005);
		rd("pending", ADDR_SERIRQ, 32'h0);
		system_reset_pin_n <= 1'b0;
		cyc(6);
		system_reset_pin_n <= 1'b1;
		cyc(6);
		chk("sys ch", 32'(channel_enable), 32'h0);
		rd("sys ctrl", ADDR_CTRL, 32'h0);
		rd("sys mask", ADDR_MASK, 32'h0);
		wr(ADDR_CTRL, EN);
		watchdog_channel_zero <= 1'b1;
		@(posedge hclk);
		watchdog_channel_zero <= 1'b0;
		cyc(3);
		rd("wdog ctrl", ADDR_CTRL, 32'h0);
		stop_test();
	end
endmodule
bind host_port_shutdown host_port_shutdown_chk chk_i (.hclk, .hresetn,
	.shutdown, .core_init, .lad_oe, .smi_oe, .pme_oe, .ga20_oe, .serirq_o,
	.serirq_oe, .core_lad_i, .core_lframe_n, .core_clkrun_n, .lreset_n_i,
	.system_reset_pin_n, .watchdog_channel_zero, .channel_enable);
`default_nettype wire
